// File: hw/lts_defines.vh
// Constants for the line trigger select block.
`ifndef LTS_DEFINES_VH
`define LTS_DEFINES_VH

// -----------------------------------------------------------------
// Origin, source and edge encodings
// -----------------------------------------------------------------
`define LTS_ORIGIN_INTERNAL 1'b0
`define LTS_ORIGIN_EXTERNAL 1'b1
`define LTS_SRC_LINK 2'h0
`define LTS_SRC_ENCODER 2'h1
`define LTS_SRC_GPIO1 2'h2
`define LTS_EDGE_POS 2'h0
`define LTS_EDGE_NEG 2'h1
`define LTS_EDGE_ANY 2'h2

// -----------------------------------------------------------------
// Field widths and reset values
// -----------------------------------------------------------------
`define LTS_PERIOD_W 24
`define LTS_DELAY_W 24
`define LTS_EXPO_W 24
`define LTS_PERIOD_RST 24'h0009c4
`define LTS_SYNC_STAGES 2

`endif

// File: hw/lts_sync_edge.v
// Two-stage synchroniser with transition detection for one input.
`timescale 1ns/100ps
`default_nettype none
`include "lts_defines.vh"

module lts_sync_edge
(
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Asynchronous level in
  input wire din,
  // Synchronised level and transitions
  output reg level,
  output wire rise,
  output wire fall
);

  reg meta_r;
  reg sync_r;

  // The first stage feeds only the second; edges are taken past that.
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      meta_r <= din;
      sync_r <= meta_r;
      level <= sync_r;
    end
  end

  assign rise = sync_r & ~level;
  assign fall = ~sync_r & level;

endmodule // lts_sync_edge

`default_nettype wire

// File: hw/lts_line_trigger.v
// Line trigger selection, edge qualification, delay and exposure timing.
`timescale 1ns/100ps
`default_nettype none
`include "lts_defines.vh"

// Contract
// - Internal origin paces lines from the internal line-rate generator and ignores external sources.
// - External origin starts each line from the link trigger, the encoder phases or a general-purpose input.
// - The external selector picks one source and is used only while the origin is external.
// - Link selection takes triggers from frame grabber trigger messages.
// - Encoder selection derives triggers from the two shaft encoder phases.
// - Line one selection derives triggers from general-purpose line one.
// - Positive-transition mode accepts each low-to-high change after optional inversion.
// - For link and line one, negative-transition mode accepts only high-to-low changes.
// - Either-transition mode accepts every change.
// - Each accepted trigger raises a line-begin event unless a delay is running; the timed exposure starts at the sensor trigger.
// - The sensor trigger can be delayed by a programmable count after acceptance.
// - In motion mode every encoder increment in either direction yields a trigger.

module lts_line_trigger
#(
  parameter PERIOD_W = `LTS_PERIOD_W,
  parameter DELAY_W = `LTS_DELAY_W,
  parameter EXPO_W = `LTS_EXPO_W
)
(
  // Clock and reset
  input wire SYS_CLK,
  input wire ARST_N,
  // Configuration
  input wire TRIGGER_ORIGIN_SELECT,
  input wire [1:0] EXTERNAL_TRIGGER_SELECT,
  input wire [1:0] TRIGGER_EDGE_SELECT,
  input wire LINE_INVERT,
  input wire [PERIOD_W-1:0] INTERNAL_LINE_RATE,
  input wire [DELAY_W-1:0] SENSOR_TRIGGER_LAG,
  input wire [EXPO_W-1:0] EXPOSURE_LENGTH,
  // External trigger inputs
  input wire LINK_TRIGGER,
  input wire ENC_PHASE_A,
  input wire ENC_PHASE_B,
  input wire GPIO_LINE_ONE,
  // Outputs to the sensor timing
  output reg LINE_BEGIN_EVENT,
  output reg SENSOR_TRIGGER,
  output reg EXPOSURE_ACTIVE,
  output reg TRIGGER_MISSED
);

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  wire [3:0] raw_in;
  wire [3:0] lvl;
  wire [3:0] rise;
  wire [3:0] fall;
  assign raw_in = {GPIO_LINE_ONE, ENC_PHASE_B, ENC_PHASE_A, LINK_TRIGGER};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      lts_sync_edge u_sync
      (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .din(raw_in[gi]),
        .level(lvl[gi]),
        .rise(rise[gi]),
        .fall(fall[gi])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // Encoder increment pulse
  // -----------------------------------------------------------------
  // Any phase change is one quadrature step; motion mode counts both ways.
  reg enc_pulse_r;
  wire enc_step;
  assign enc_step = rise[1] | fall[1] | rise[2] | fall[2];

  always @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      enc_pulse_r <= 1'b0;
    else if (enc_step)
      enc_pulse_r <= ~enc_pulse_r;
  end

  // -----------------------------------------------------------------
  // Source select, inversion and edge qualification
  // -----------------------------------------------------------------
  reg src_lvl;
  reg src_prev_r;
  reg src_valid_r;
  reg ext_accept;
  reg [1:0] sel_prev_r;
  reg inv_prev_r;
  wire src_inv;

  // The encoder toggle is a step per change, so any edge of it counts.
  always @*
  begin
    case (EXTERNAL_TRIGGER_SELECT)
      `LTS_SRC_LINK: src_lvl = lvl[0];
      `LTS_SRC_ENCODER: src_lvl = enc_pulse_r;
      `LTS_SRC_GPIO1: src_lvl = lvl[3];
      default: src_lvl = 1'b0;
    endcase
  end

  assign src_inv = src_lvl ^ LINE_INVERT;

  always @*
  begin
    ext_accept = 1'b0;
    // A selector or invert change is masked in the cycle it appears and in the next one.
    if (src_valid_r && sel_prev_r == EXTERNAL_TRIGGER_SELECT && inv_prev_r == LINE_INVERT)
    begin
      if (EXTERNAL_TRIGGER_SELECT == `LTS_SRC_ENCODER)
        ext_accept = src_inv ^ src_prev_r;
      else
      begin
        case (TRIGGER_EDGE_SELECT)
          `LTS_EDGE_POS: ext_accept = src_inv & ~src_prev_r;
          `LTS_EDGE_NEG: ext_accept = ~src_inv & src_prev_r;
          `LTS_EDGE_ANY: ext_accept = src_inv ^ src_prev_r;
          default: ext_accept = 1'b0;
        endcase
      end
    end
  end

  // A selector change reloads the history so it is not seen as an edge.
  always @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      src_prev_r <= 1'b0;
      src_valid_r <= 1'b0;
      sel_prev_r <= 2'h0;
      inv_prev_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= src_inv;
      sel_prev_r <= EXTERNAL_TRIGGER_SELECT;
      inv_prev_r <= LINE_INVERT;
      src_valid_r <= (sel_prev_r == EXTERNAL_TRIGGER_SELECT) && (inv_prev_r == LINE_INVERT);
    end
  end

  // -----------------------------------------------------------------
  // Internal line-rate generator
  // -----------------------------------------------------------------
  localparam [PERIOD_W-1:0] period_one = {{(PERIOD_W-1){1'b0}}, 1'b1};
  reg [PERIOD_W-1:0] rate_cnt_r;
  reg int_tick_r;

  always @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rate_cnt_r <= {PERIOD_W{1'b0}};
      int_tick_r <= 1'b0;
    end
    else if (TRIGGER_ORIGIN_SELECT != `LTS_ORIGIN_INTERNAL)
    begin
      rate_cnt_r <= {PERIOD_W{1'b0}};
      int_tick_r <= 1'b0;
    end
    else if (rate_cnt_r + period_one >= INTERNAL_LINE_RATE)
    begin
      rate_cnt_r <= {PERIOD_W{1'b0}};
      int_tick_r <= 1'b1;
    end
    else
    begin
      rate_cnt_r <= rate_cnt_r + period_one;
      int_tick_r <= 1'b0;
    end
  end

  wire accept;
  assign accept = (TRIGGER_ORIGIN_SELECT == `LTS_ORIGIN_INTERNAL) ? int_tick_r : ext_accept;

  // -----------------------------------------------------------------
  // Line-begin event, delay and exposure
  // -----------------------------------------------------------------
  // A trigger arriving while the delay still runs is dropped and flagged.
  reg delay_busy_r;
  reg [DELAY_W-1:0] delay_cnt_r;
  reg [EXPO_W-1:0] expo_cnt_r;
  localparam [DELAY_W-1:0] delay_one = {{(DELAY_W-1){1'b0}}, 1'b1};
  localparam [EXPO_W-1:0] expo_one = {{(EXPO_W-1){1'b0}}, 1'b1};
  wire fire;
  assign fire = delay_busy_r ? (delay_cnt_r == {DELAY_W{1'b0}}) :
                (accept && SENSOR_TRIGGER_LAG == {DELAY_W{1'b0}});

  always @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      LINE_BEGIN_EVENT <= 1'b0;
      SENSOR_TRIGGER <= 1'b0;
      EXPOSURE_ACTIVE <= 1'b0;
      TRIGGER_MISSED <= 1'b0;
      delay_busy_r <= 1'b0;
      delay_cnt_r <= {DELAY_W{1'b0}};
      expo_cnt_r <= {EXPO_W{1'b0}};
    end
    else
    begin
      LINE_BEGIN_EVENT <= accept && !delay_busy_r;
      TRIGGER_MISSED <= accept && delay_busy_r;
      SENSOR_TRIGGER <= fire;
      if (delay_busy_r)
      begin
        if (delay_cnt_r == {DELAY_W{1'b0}})
          delay_busy_r <= 1'b0;
        else
          delay_cnt_r <= delay_cnt_r - delay_one;
      end
      else if (accept && SENSOR_TRIGGER_LAG != {DELAY_W{1'b0}})
      begin
        delay_busy_r <= 1'b1;
        delay_cnt_r <= SENSOR_TRIGGER_LAG - delay_one;
      end
      if (fire && EXPOSURE_LENGTH != {EXPO_W{1'b0}})
      begin
        EXPOSURE_ACTIVE <= 1'b1;
        expo_cnt_r <= EXPOSURE_LENGTH - expo_one;
      end
      else if (expo_cnt_r != {EXPO_W{1'b0}})
        expo_cnt_r <= expo_cnt_r - expo_one;
      else
        EXPOSURE_ACTIVE <= 1'b0;
    end
  end

endmodule // lts_line_trigger

`default_nettype wire

// File: test/lts_trig_src.sv
// Model of the external trigger sources that drive the block.
`timescale 1ns/100ps
`default_nettype none
module lts_trig_src
(
  // Clock
  input wire logic clk,
  // Trigger lines
  output var logic link_trg,
  output var logic enc_a,
  output var logic enc_b,
  output var logic gpio1
);
  initial {link_trg, enc_a, enc_b, gpio1} = 4'h0;
  // Lines 0 link, 1 phase A, 2 line one, 3 phase B; each level holds at least two clocks.
  task automatic drive(input logic [1:0] sel, input logic v);
    @(negedge clk);
    case (sel)
      2'h0: link_trg = v;
      2'h1: enc_a = v;
      2'h2: gpio1 = v;
      default: enc_b = v;
    endcase
    repeat (2) @(negedge clk);
  endtask
endmodule // lts_trig_src
`default_nettype wire

// File: test/lts_line_trigger_checker.sv
// Port assertions for the line trigger select block.
`timescale 1ns/100ps
`default_nettype none
module lts_line_trigger_checker
#(
  parameter PERIOD_W = 24,
  parameter DELAY_W = 24,
  parameter EXPO_W = 24
)
(
  // Clock, reset and configuration
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic TRIGGER_ORIGIN_SELECT,
  input wire logic [1:0] EXTERNAL_TRIGGER_SELECT,
  input wire logic [1:0] TRIGGER_EDGE_SELECT,
  input wire logic LINE_INVERT,
  input wire logic [PERIOD_W-1:0] INTERNAL_LINE_RATE,
  input wire logic [DELAY_W-1:0] SENSOR_TRIGGER_LAG,
  input wire logic [EXPO_W-1:0] EXPOSURE_LENGTH,
  // Trigger inputs and outputs
  input wire logic LINK_TRIGGER,
  input wire logic ENC_PHASE_A,
  input wire logic ENC_PHASE_B,
  input wire logic GPIO_LINE_ONE,
  input wire logic LINE_BEGIN_EVENT,
  input wire logic SENSOR_TRIGGER,
  input wire logic EXPOSURE_ACTIVE,
  input wire logic TRIGGER_MISSED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  wire ext = TRIGGER_ORIGIN_SELECT;
  wire lbe = LINE_BEGIN_EVENT;
  wire lag0 = SENSOR_TRIGGER_LAG == 0;
  wire plain = ext && !LINE_INVERT && lag0;
  a_reset_quiet: assert property ($rose(ARST_N) |-> !lbe && !SENSOR_TRIGGER)
    else $error("pulse right after reset");
  a_lag_zero: assert property (lbe && lag0 |-> SENSOR_TRIGGER)
    else $error("sensor trigger late with zero lag");
  a_expo_span: assert property (SENSOR_TRIGGER && EXPOSURE_LENGTH == 2
    |-> EXPOSURE_ACTIVE ##1 EXPOSURE_ACTIVE ##1 (!EXPOSURE_ACTIVE || SENSOR_TRIGGER)) else $error("exposure span");
  a_missed_excl: assert property (TRIGGER_MISSED |-> !lbe)
    else $error("missed trigger began a line");
  a_int_period: assert property ((!ext && INTERNAL_LINE_RATE == 4 && lbe) ##1 (!ext)[*4]
    |-> lbe && !$past(lbe)) else $error("internal line period");
  a_gpio_rise: assert property (plain && EXTERNAL_TRIGGER_SELECT == 2 && TRIGGER_EDGE_SELECT == 0
    && $rose(GPIO_LINE_ONE) |-> ##[3:5] lbe) else $error("line one rise lost");
  a_link_fall: assert property (plain && EXTERNAL_TRIGGER_SELECT == 0 && TRIGGER_EDGE_SELECT == 1
    && $fell(LINK_TRIGGER) |-> ##[3:5] lbe) else $error("link fall lost");
  a_enc_step: assert property (ext && lag0 && EXTERNAL_TRIGGER_SELECT == 1
    && ($changed(ENC_PHASE_A) || $changed(ENC_PHASE_B)) |-> ##[3:5] lbe) else $error("encoder step lost");
  a_none_quiet: assert property ((ext && EXTERNAL_TRIGGER_SELECT == 3)[*6] |-> !lbe)
    else $error("line began with no source");
endmodule // lts_line_trigger_checker
bind lts_line_trigger lts_line_trigger_checker #(.PERIOD_W(PERIOD_W), .DELAY_W(DELAY_W), .EXPO_W(EXPO_W)) u_chk (.*);
`default_nettype wire

// File: test/lts_line_trigger_tb_top.sv
// Self-checking bench for the line trigger select block.
`timescale 1ns/100ps
`default_nettype none
`include "lts_defines.vh"
module lts_line_trigger_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic origin = 1'b0;
  logic [1:0] src_sel = 2'h3;
  logic [1:0] edge_sel = 2'h0;
  logic inv = 1'b0;
  logic [23:0] lag = 24'h000000;
  logic [23:0] expo = 24'h000002;
  logic [23:0] rate = 24'h000004;
  logic [7:0] cfg_lbe;
  logic saw_missed;
  int fail_count = 0;
  int checked = 0;
  wire link, enc_a, enc_b, gpio1, lbe, st, ea, missed;
  always #2 clk = ~clk;
  lts_trig_src src (.clk(clk), .link_trg(link), .enc_a(enc_a), .enc_b(enc_b), .gpio1(gpio1));
  lts_line_trigger dut (.SYS_CLK(clk), .ARST_N(arst_n), .TRIGGER_ORIGIN_SELECT(origin),
    .EXTERNAL_TRIGGER_SELECT(src_sel), .TRIGGER_EDGE_SELECT(edge_sel), .LINE_INVERT(inv),
    .INTERNAL_LINE_RATE(rate), .SENSOR_TRIGGER_LAG(lag), .EXPOSURE_LENGTH(expo),
    .LINK_TRIGGER(link), .ENC_PHASE_A(enc_a), .ENC_PHASE_B(enc_b), .GPIO_LINE_ONE(gpio1),
    .LINE_BEGIN_EVENT(lbe), .SENSOR_TRIGGER(st), .EXPOSURE_ACTIVE(ea), .TRIGGER_MISSED(missed));
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic o, input logic [1:0] s, input logic [1:0] e, input logic i, input logic [23:0] l);
    @(negedge clk);
    origin = o;
    src_sel = s;
    edge_sel = e;
    inv = i;
    lag = l;
    count(8, cfg_lbe);
  endtask
  task automatic count(input int n, output logic [7:0] c);
    c = 8'h00;
    repeat (n)
    begin
      @(negedge clk);
      c += {7'h00, lbe};
    end
  endtask
  // Waits for the sensor trigger (w high) or a line begin, noting missed triggers.
  task automatic wait_hi(input logic w, output int k);
    k = 0;
    while ((w ? st : lbe) !== 1'b1)
    begin
      @(negedge clk);
      saw_missed |= missed;
      k++;
      if (k == 30)
      begin
        fail_count++;
        conclude();
      end
    end
  endtask
  task automatic t_edges;
    logic [7:0] c;
    for (int s = 0; s < 3; s += 2)
      for (int e = 0; e < 3; e++)
        for (int i = 0; i < 2; i++)
        begin
          cfg(1'b1, 2'(s), 2'(e), 1'(i), 24'h000000);
          chk("switch", cfg_lbe, 8'h00);
          src.drive(2'(s), 1'b1);
          count(8, c);
          chk("rise", c, {7'h00, e == 2 || (e == 0) != (i == 1)});
          src.drive(2'(s), 1'b0);
          count(8, c);
          chk("fall", c, {7'h00, e == 2 || (e == 1) != (i == 1)});
        end
  endtask
  task automatic t_encoder;
    logic [7:0] c;
    cfg(1'b1, `LTS_SRC_ENCODER, `LTS_EDGE_NEG, 1'b0, 24'h000000);
    for (int k = 0; k < 8; k++)
    begin
      src.drive((k[0] == (k > 3)) ? 2'h1 : 2'h3, ~k[1]);
      count(6, c);
      chk("encoder step", c, 8'h01);
    end
  endtask
  task automatic t_lag;
    int k;
    cfg(1'b1, `LTS_SRC_GPIO1, `LTS_EDGE_ANY, 1'b0, 24'h000009);
    src.drive(2'h2, 1'b1);
    wait_hi(1'b0, k);
    saw_missed = 1'b0;
    src.drive(2'h2, 1'b0);
    wait_hi(1'b1, k);
    chk("sensor lag", 8'(k + 3), 8'h09);
    chk("exposure", {7'h00, ea}, 8'h01);
    chk("missed", {7'h00, saw_missed}, 8'h01);
  endtask
  task automatic t_quiet;
    logic [7:0] c;
    cfg(1'b1, 2'h3, `LTS_EDGE_ANY, 1'b0, 24'h000000);
    src.drive(2'h2, 1'b1);
    count(8, c);
    chk("no source", c, 8'h00);
    cfg(1'b0, `LTS_SRC_GPIO1, `LTS_EDGE_ANY, 1'b0, 24'h000000);
    fork
      src.drive(2'h2, 1'b0);
      count(40, c);
    join
    chk("internal lines", c, 8'h0a);
    @(negedge clk);
    rate = 24'h000006;
    repeat (8) @(negedge clk);
    count(36, c);
    chk("internal rate", c, 8'h06);
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    t_edges();
    t_encoder();
    t_lag();
    t_quiet();
    conclude();
  end
endmodule // lts_line_trigger_tb_top
`default_nettype wire
